// ===== ppoc_defs.vh
// constants for the pwm pin output control block
// assumes one 16-bit control register on a plain strobe port
`ifndef PPOC_DEFS_VH
`define PPOC_DEFS_VH
`define PPOC_ADDR_W        4
`define PPOC_OFF_IOCTL     4'h0
`define PPOC_OFF_STATUS    4'h1
`define PPOC_IOCTL_RESET   16'h0000
`define PPOC_B_HIGH_OWNER  15
`define PPOC_B_LOW_OWNER   14
`define PPOC_B_HIGH_POL    13
`define PPOC_B_LOW_POL     12
`define PPOC_B_MODE_HI     11
`define PPOC_B_MODE_LO     10
`define PPOC_B_HIGH_OVR    9
`define PPOC_B_LOW_OVR     8
`define PPOC_B_OVR_HI      7
`define PPOC_B_OVR_LO      6
`define PPOC_B_FLT_HI      5
`define PPOC_B_FLT_LO      4
`define PPOC_B_CL_HI       3
`define PPOC_B_CL_LO       2
`define PPOC_B_EXCHANGE    1
`define PPOC_B_OVERRIDE_SYNC_SELECT       0
`define PPOC_MODE_COMPL    2'h0
`define PPOC_MODE_REDUND   2'h1
`define PPOC_MODE_PUSHPULL 2'h2
`define PPOC_MODE_INDEP    2'h3
`endif

// ===== ppoc_gate_drv.sv
// behavioural gate drivers on the pin pair
// assumes pins are released when their enable is low
`timescale 1ns/1ps
`default_nettype none
module ppoc_gate_drv (
    input  wire logic i_hi,
    input  wire logic i_hi_oe,
    input  wire logic i_lo,
    input  wire logic i_lo_oe,
    output var  logic o_both_on
);
    // a released pin floats low on the driver's pull-down
    always @* o_both_on = (i_hi & i_hi_oe) & (i_lo & i_lo_oe);
endmodule // ppoc_gate_drv
`default_nettype wire

// ===== ppoc_pin_ctl.v
// pwm pin pair output stage: ownership, polarity, modes, overrides, fault states
// assumes generator signals and period boundary are on i_clock; fault pins are async
`timescale 1ns/1ps
`default_nettype none
`include "ppoc_defs.vh"
module ppoc_pin_ctl (
    input  wire        i_clock,          // 200 MHz module clock
    input  wire        i_sys_rst,        // async reset, active high
    input  wire [3:0]  i_addr,           // register index
    input  wire [15:0] i_wdata,          // write data
    input  wire        i_wr,             // write strobe
    input  wire        i_rd,             // read strobe
    output reg  [15:0] o_rdata,          // read data, cycle after strobe
    input  wire        i_gen_high,       // generator high-side active level
    input  wire        i_gen_low,        // generator low-side active level
    input  wire        i_period_edge,    // time base boundary pulse
    input  wire        i_fault_pin,      // fault input, async, active high
    input  wire        i_climit_pin,     // current limit input, async, active high
    input  wire        i_independent_fault_select, // independent fault handling
    input  wire        i_gpio_high,      // gpio level for high pin
    input  wire        i_gpio_high_oe,   // gpio enable for high pin
    input  wire        i_gpio_low,       // gpio level for low pin
    input  wire        i_gpio_low_oe,    // gpio enable for low pin
    output reg         o_output_high_side,    // high pin level
    output reg         o_output_high_side_oe, // high pin enable
    output reg         o_output_low_side,     // low pin level
    output reg         o_output_low_side_oe   // low pin enable
);
    parameter HAS_INDEPENDENT = 1'b1; // true independent mode present
    ////////////////////////////////////////////////////////////////////
    // registers
    // control word and the copies that actually steer the pins
    reg  [15:0] ioctl_q;        // control register
    reg  [1:0]  ovr_en_q;       // applied override enables {high,low}
    reg  [1:0]  ovr_val_q;      // applied override values {high,low}
    reg         push_phase_q;   // push-pull alternation
    wire        fault_s;        // synced fault
    wire        climit_s;       // synced current limit
    wire [1:0]  mode = ioctl_q[`PPOC_B_MODE_HI:`PPOC_B_MODE_LO];
    wire [1:0]  prot_raw = {i_fault_pin, i_climit_pin}; // raw protection pins {fault,limit}
    wire [1:0]  prot_s;         // synced protection levels {fault,limit}
    genvar      gi;             // synchroniser index
    // synchronise the async protection pins before any logic
    // two stages cost two cycles of reaction but keep metastability off the pins
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            ppoc_sync2 u_sync (
                .i_clock   (i_clock),
                .i_sys_rst (i_sys_rst),
                .i_async   (prot_raw[gi]),
                .o_sync    (prot_s[gi])
            );
        end
    endgenerate
    assign fault_s  = prot_s[1];
    assign climit_s = prot_s[0];
    // decode a register index
    // shared by the write and the read decode
    function hit;
        input [3:0] a;
        input [3:0] off;
        begin
            hit = (a == off);
        end
    endfunction
    ////////////////////////////////////////////////////////////////////
    // register port: write, read data one cycle later
    // the port never stalls the master; writes to other indices are dropped
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ioctl_q <= `PPOC_IOCTL_RESET;
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= 16'h0000; // data stands only one cycle
            if (i_wr && hit(i_addr, `PPOC_OFF_IOCTL)) begin
                ioctl_q <= i_wdata;
            end
            if (i_rd) begin
                if (hit(i_addr, `PPOC_OFF_IOCTL)) begin
                    o_rdata <= ioctl_q;
                end else if (hit(i_addr, `PPOC_OFF_STATUS)) begin
                    // live state: protection inputs and applied overrides
                    // shows what the pins use now, which may lag the control word
                    o_rdata <= {10'h000, fault_s, climit_s, ovr_en_q, ovr_val_q};
                end
                // unmapped indices read zero
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // override capture: immediate or at the time base boundary
    // with the sync bit clear the copy trails the register by one cycle;
    // with it set a change waits for the boundary so no period is cut short
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ovr_en_q  <= 2'h0;
            ovr_val_q <= 2'h0;
        end else if (!ioctl_q[`PPOC_B_OVERRIDE_SYNC_SELECT] || i_period_edge) begin
            ovr_en_q  <= {ioctl_q[`PPOC_B_HIGH_OVR], ioctl_q[`PPOC_B_LOW_OVR]};
            ovr_val_q <= {ioctl_q[`PPOC_B_OVR_HI], ioctl_q[`PPOC_B_OVR_LO]};
        end
    end
    // push-pull alternates on each period
    // the phase only moves on a boundary, so each period drives one pin
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            push_phase_q <= 1'b0;
        end else if (i_period_edge) begin
            push_phase_q <= ~push_phase_q;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // active-level path: mode, override, protection, exchange
    reg act_h;  // high active level
    reg act_l;  // low active level
    reg sig_h;  // after exchange
    reg sig_l;  // low after exchange
    always @* begin
        act_h = i_gen_high;
        act_l = i_gen_low;
        // start from the generator levels, then let the mode shape the low side, and in push-pull the high side too
        case (mode)
            `PPOC_MODE_COMPL: begin
                act_l = ~i_gen_high;
            end
            `PPOC_MODE_REDUND: begin
                act_l = i_gen_high;
            end
            `PPOC_MODE_PUSHPULL: begin
                // only one side is live in each period
                act_h = i_gen_high & ~push_phase_q;
                act_l = i_gen_high &  push_phase_q;
            end
            `PPOC_MODE_INDEP: begin
                // absent variant falls back to complementary
                if (!HAS_INDEPENDENT) begin
                    act_l = ~i_gen_high;
                end
            end
            default: begin
                // unreachable with two bits; keeps the decode total
                act_l = ~i_gen_high;
            end
        endcase
        // overrides replace the mode result, one pin at a time
        if (ovr_en_q[1]) begin
            act_h = ovr_val_q[1];
        end
        if (ovr_en_q[0]) begin
            act_l = ovr_val_q[0];
        end
        // protection outranks overrides; fault outranks current limit unless the fault select is independent
        // the fault select lives in another register and arrives on this clock
        if (!i_independent_fault_select) begin
            if (fault_s) begin
                act_h = ioctl_q[`PPOC_B_FLT_HI];
                act_l = ioctl_q[`PPOC_B_FLT_LO];
            end else if (climit_s) begin
                act_h = ioctl_q[`PPOC_B_CL_HI];
                act_l = ioctl_q[`PPOC_B_CL_LO];
            end
        end else begin
            // independent: limit feeds high, fault feeds low, cl bits unused
            if (climit_s) begin
                act_h = ioctl_q[`PPOC_B_FLT_HI];
            end
            if (fault_s) begin
                act_l = ioctl_q[`PPOC_B_FLT_LO];
            end
        end
        // exchange runs last, so protection and override states follow the swap
        if (ioctl_q[`PPOC_B_EXCHANGE]) begin
            sig_h = act_l;
            sig_l = act_h;
        end else begin
            sig_h = act_h;
            sig_l = act_l;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // pin stage: polarity and ownership, registered
    // registering the pins keeps decode glitches away from the gate drivers
    // gpio-owned pins take the gpio level and enable one cycle late
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_output_high_side    <= 1'b0;
            o_output_high_side_oe <= 1'b0;
            o_output_low_side     <= 1'b0;
            o_output_low_side_oe  <= 1'b0;
        end else begin
            if (ioctl_q[`PPOC_B_HIGH_OWNER]) begin
                // polarity applies to every active level source
                o_output_high_side    <= sig_h ^ ioctl_q[`PPOC_B_HIGH_POL];
                o_output_high_side_oe <= 1'b1;
            end else begin
                o_output_high_side    <= i_gpio_high;
                o_output_high_side_oe <= i_gpio_high_oe;
            end
            if (ioctl_q[`PPOC_B_LOW_OWNER]) begin
                o_output_low_side     <= sig_l ^ ioctl_q[`PPOC_B_LOW_POL];
                o_output_low_side_oe  <= 1'b1;
            end else begin
                o_output_low_side     <= i_gpio_low;
                o_output_low_side_oe  <= i_gpio_low_oe;
            end
        end
    end
endmodule // ppoc_pin_ctl
`default_nettype wire

// ===== ppoc_pin_ctl_properties.sv
// checker for the pwm pin output stage
// assumes it sees only the ports of ppoc_pin_ctl
`timescale 1ns/1ps
`default_nettype none
module ppoc_chk (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic [3:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        i_gen_high,
    input wire logic        i_gen_low,
    input wire logic        i_fault_pin,
    input wire logic        i_climit_pin,
    input wire logic        i_independent_fault_select,
    input wire logic        i_gpio_high,
    input wire logic        i_gpio_high_oe,
    input wire logic        i_gpio_low,
    input wire logic        i_gpio_low_oe,
    input wire logic        o_output_high_side,
    input wire logic        o_output_high_side_oe,
    input wire logic        o_output_low_side,
    input wire logic        o_output_low_side_oe
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic [15:0] c_q;  // shadow of the control word
    logic [2:0]  st_q; // cycles since last write
    logic [2:0]  fl_q; // cycles fault held
    logic [2:0]  qt_q; // cycles with no fault or limit
    logic        up_q; // high from the first edge after reset
    wire g = i_gen_high;
    wire [1:0] pin = {o_output_high_side, o_output_low_side};
    wire [1:0] pl = c_q[13:12];
    wire ow = c_q[15:14] == 2'h3 && qt_q > 3'h3;
    // settled pwm-owned pins: no override, exchange or pending sync, applied copy caught up
    wire on = ow && c_q[9:8] == 2'h0 && c_q[1:0] == 2'h0 && st_q != 3'h0;
    ////////////////////////////////////////////////////////////////
    // the counters saturate at 7 so they never wrap into a false pass
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            c_q <= 16'h0000;
            st_q <= 3'h0;
            fl_q <= 3'h0;
            qt_q <= 3'h0;
            up_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
            if (i_wr && i_addr == 4'h0) c_q <= i_wdata;
            st_q <= (i_wr && i_addr == 4'h0) ? 3'h0 : st_q + {2'h0, st_q != 3'h7};
            fl_q <= i_fault_pin ? fl_q + {2'h0, fl_q != 3'h7} : 3'h0;
            qt_q <= (i_fault_pin | i_climit_pin) ? 3'h0 : qt_q + {2'h0, qt_q != 3'h7};
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_gpio_h;
        up_q && !c_q[15] |=> o_output_high_side == $past(i_gpio_high) &&
            o_output_high_side_oe == $past(i_gpio_high_oe);
    endproperty
    a_gpio_h: assert property (p_gpio_h) else $error("high pin not gpio");
    property p_gpio_l;
        up_q && !c_q[14] |=> o_output_low_side == $past(i_gpio_low) &&
            o_output_low_side_oe == $past(i_gpio_low_oe);
    endproperty
    a_gpio_l: assert property (p_gpio_l) else $error("low pin not gpio");
    property p_compl; on && c_q[11:10] == 2'h0 |=> pin == $past({g, !g} ^ pl); endproperty
    a_compl: assert property (p_compl) else $error("complementary pins wrong");
    property p_redund; on && c_q[11:10] == 2'h1 |=> pin == $past({g, g} ^ pl); endproperty
    a_redund: assert property (p_redund) else $error("redundant pins wrong");
    property p_indep; on && c_q[11:10] == 2'h3 |=> pin == $past({g, i_gen_low} ^ pl); endproperty
    a_indep: assert property (p_indep) else $error("independent pins wrong");
    property p_swap;
        ow && c_q[9:0] == 10'h002 && c_q[11:10] == 2'h0 && st_q != 3'h0 |=>
            pin == $past({!g, g} ^ pl);
    endproperty
    a_swap: assert property (p_swap) else $error("exchange wrong");
    property p_fault;
        c_q[15:14] == 2'h3 && !c_q[1] && fl_q > 3'h4 && st_q > 3'h1 &&
            !i_independent_fault_select |-> pin == (c_q[5:4] ^ pl);
    endproperty
    a_fault: assert property (p_fault) else $error("fault state wrong");
    property p_ovr;
        ow && c_q[9:8] == 2'h3 && c_q[1:0] == 2'h0 && st_q > 3'h3 |->
            pin == (c_q[7:6] ^ pl);
    endproperty
    a_ovr: assert property (p_ovr) else $error("override wrong");
    property p_read; i_rd && i_addr == 4'h0 |=> o_rdata == $past(c_q); endproperty
    a_read: assert property (p_read) else $error("readback wrong");
endmodule // ppoc_chk
bind ppoc_pin_ctl ppoc_chk u_chk (.*);
`default_nettype wire

// ===== ppoc_pin_ctl_test.sv
// testbench: register writes then pin checks
// assumes ppoc_defs.vh and the design are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module ppoc_pin_ctl_test;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, flt = 1'b0, cl = 1'b0;
    logic gh = 1'b1, gl = 1'b0, pe = 1'b0;
    logic [3:0] a = 4'h0;
    logic [15:0] wd = 16'h0000, rdat;
    logic oh, ohe, ol, ole, both;
    int num_errors = 0, n_checks = 0, cyc = 0;
    ppoc_pin_ctl dut (.i_clock(clk), .i_sys_rst(rst), .i_addr(a), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_gen_high(gh), .i_gen_low(gl),
        .i_period_edge(pe), .i_fault_pin(flt), .i_climit_pin(cl),
        .i_independent_fault_select(1'b0), .i_gpio_high(1'b1), .i_gpio_high_oe(1'b1),
        .i_gpio_low(1'b1), .i_gpio_low_oe(1'b0), .o_output_high_side(oh),
        .o_output_high_side_oe(ohe), .o_output_low_side(ol), .o_output_low_side_oe(ole));
    ppoc_gate_drv u_drv (.i_hi(oh), .i_hi_oe(ohe), .i_lo(ol), .i_lo_oe(ole), .o_both_on(both));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrt(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk); a <= ad; wd <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] ad, input logic [15:0] e);
        @(posedge clk); a <= ad; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    // let pins settle, compare {both_on, h, l, h_oe, l_oe}
    task automatic pk(input logic [3:0] e);
        repeat (4) @(posedge clk);
        #1 chk({11'h000, both, oh, ol, ohe, ole}, {11'h000, &e, e});
    endtask
    // one time base boundary pulse
    task automatic pulse;
        @(posedge clk);
        pe <= 1'b1;
        @(posedge clk);
        pe <= 1'b0;
    endtask
    // write, read back, then check the pins
    task automatic t(input logic [15:0] c, input logic [3:0] e);
        wrt(4'h0, c);
        rdc(4'h0, c);
        pk(e);
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) if (++cyc > 3000) begin num_errors++; report_and_stop; end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(4'h0, 16'h0000);
        t(16'h0000, 4'hE);
        t(16'hC000, 4'hB);
        t(16'hE000, 4'h3);
        t(16'hD000, 4'hF);
        t(16'hC400, 4'hF);
        t(16'hDC00, 4'hF);
        t(16'hC002, 4'h7);
        t(16'hF380, 4'h7);
        t(16'hC340, 4'h7);
        @(posedge clk) flt <= 1'b1;
        t(16'hC010, 4'h7);
        @(posedge clk) flt <= 1'b0;
        @(posedge clk) cl <= 1'b1;
        t(16'hC004, 4'h7);
        @(posedge clk) cl <= 1'b0;
        t(16'hC800, 4'hB);
        pulse;
        pk(4'h7);
        t(16'hCC00, 4'hB);
        @(posedge clk);
        gh <= 1'b0;
        gl <= 1'b1;
        pk(4'h7);
        @(posedge clk);
        gh <= 1'b1;
        pk(4'hF);
        t(16'hC341, 4'hB);
        rdc(4'h1, 16'h0000);
        pulse;
        pk(4'h7);
        rdc(4'h1, 16'h000D);
        rdc(4'h5, 16'h0000);
        wrt(4'h1, 16'hFFFF);
        rdc(4'h0, 16'hC341);
        report_and_stop;
    end
endmodule // ppoc_pin_ctl_test
`default_nettype wire

// ===== ppoc_sync2.v
// two-flop synchroniser for pin inputs
// assumes input is asynchronous to i_clock
`timescale 1ns/1ps
`default_nettype none
module ppoc_sync2 (
    input  wire i_clock,   // module clock
    input  wire i_sys_rst, // async reset, active high
    input  wire i_async,   // raw pin level
    output wire o_sync     // settled level
);
    reg meta_q; // first stage, read only by second stage
    reg sync_q; // second stage
    // plain two-stage chain
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule // ppoc_sync2
`default_nettype wire
